// ==== tfc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tfc_top (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [tfc_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic prio0_pause_request,
   input wire logic prio1_pause_request,
   input wire logic prio2_pause_request,
   output logic fc_frame_start,
   output logic [1:0] fc_frame_prio,
   output logic fc_frame_xon,
   output logic [7:0] fc_sa_octet,
   output logic fc_sa_valid,
   output logic fc_sa_last,
   output logic [tfc_pkg::MTU_W-1:0] tx_max_len,
   output logic tx_mtu_limit_en,
   output logic pfc_on
);
   import tfc_pkg::*;

   typedef struct packed {
      logic [NUM_PRIO-1:0] prio_en;
      logic auto_xon;
      logic pfc_en;
      logic lfc_en;
      logic [SA_W-1:0] sa;
      logic [MTU_W-1:0] mtu_size;
      logic mtu_en;
      logic [MTU_W-1:0] max_len;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      tfc_arb_t arb;
      logic [1:0] cur_prio;
      logic cur_xon;
      logic start;
      logic [7:0] frames;
   } tfc_top_st_t;

   tfc_top_st_t s_q;
   tfc_top_st_t s_d;
   logic [NUM_PRIO-1:0] req_v;
   logic [NUM_PRIO-1:0] xoff_p;
   logic [NUM_PRIO-1:0] xon_p;
   logic [NUM_PRIO-1:0] gx;
   logic [NUM_PRIO-1:0] gn;
   logic [NUM_REG-1:0] hit;

   tfc_oct_if oif ();

   function automatic logic [NUM_REG-1:0] tfc_dec(input logic [ADDR_W-1:0] a);
      tfc_dec = '0;
      tfc_dec[IDX_CTRL] = (a == OFS_CTRL);
      tfc_dec[IDX_SA_LO] = (a == OFS_SA_LO);
      tfc_dec[IDX_SA_HI] = (a == OFS_SA_HI);
      tfc_dec[IDX_MTU] = (a == OFS_MTU);
      tfc_dec[IDX_STAT] = (a == OFS_STAT);
   endfunction

   function automatic logic [31:0] tfc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
      tfc_merge = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            tfc_merge[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
   endfunction

   function automatic logic [31:0] tfc_ctrl_word(input tfc_top_st_t s);
      tfc_ctrl_word = '0;
      tfc_ctrl_word[CTRL_PRIO_LSB +: NUM_PRIO] = s.prio_en;
      tfc_ctrl_word[CTRL_AUTO_XON] = s.auto_xon;
      tfc_ctrl_word[CTRL_PFC_EN] = s.pfc_en;
      tfc_ctrl_word[CTRL_LFC_EN] = s.lfc_en;
   endfunction

   function automatic logic [31:0] tfc_mtu_word(input tfc_top_st_t s);
      tfc_mtu_word = '0;
      tfc_mtu_word[MTU_W-1:0] = s.mtu_size;
      tfc_mtu_word[MTU_EN_BIT] = s.mtu_en;
   endfunction

   assign req_v = {prio2_pause_request, prio1_pause_request, prio0_pause_request};
   assign hit = tfc_dec(paddr);

   for (genvar g = 0; g < NUM_PRIO; g++) begin : g_trk
      tfc_prio_track u_trk (
         .clk_sys(clk_sys),
         .sys_rst(sys_rst),
         .req(req_v[g]),
         .enable(s_q.prio_en[g] & s_q.pfc_en),
         .auto_xon(s_q.auto_xon),
         .grant_xoff(gx[g]),
         .grant_xon(gn[g]),
         .pend_xoff(xoff_p[g]),
         .pend_xon(xon_p[g])
      );
   end

   tfc_sa_ser u_ser (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .oif(oif.slv)
   );

   // Only generated frames see the pause source address
   assign oif.start = s_q.start;
   assign oif.addr = s_q.sa;

   always_comb begin
      logic [31:0] rd;
      logic [31:0] m;
      logic wr;
      logic pick_v;
      logic pick_x;
      logic [1:0] pick_i;
      rd = '0;
      m = '0;
      wr = psel & penable & s_q.pready & pwrite;
      pick_v = 1'b0;
      pick_x = 1'b0;
      pick_i = 2'h0;
      gx = '0;
      gn = '0;
      s_d = s_q;
      s_d.start = 1'b0;

      // Register bus: answer one cycle after setup
      s_d.pready = psel & ~penable;
      if (psel && !penable) begin
         s_d.pslverr = ~|hit;
         if (hit[IDX_CTRL]) begin
            rd = tfc_ctrl_word(s_q);
         end
         if (hit[IDX_SA_LO]) begin
            rd = s_q.sa[SA_LO_W-1:0];
         end
         if (hit[IDX_SA_HI]) begin
            rd[SA_HI_W-1:0] = s_q.sa[SA_W-1:SA_LO_W];
         end
         if (hit[IDX_MTU]) begin
            rd = tfc_mtu_word(s_q);
         end
         if (hit[IDX_STAT]) begin
            rd[STAT_XOFF_LSB +: NUM_PRIO] = xoff_p;
            rd[STAT_XON_LSB +: NUM_PRIO] = xon_p;
            rd[STAT_BUSY] = (s_q.arb != ARB_IDLE);
            rd[STAT_CONFLICT] = s_q.pfc_en & s_q.lfc_en;
            rd[STAT_FRAMES_LSB +: 8] = s_q.frames;
         end
         s_d.prdata = pwrite ? 32'h0 : rd;
      end
      if (wr) begin
         if (hit[IDX_CTRL]) begin
            m = tfc_merge(tfc_ctrl_word(s_q), pwdata, pstrb);
            s_d.prio_en = m[CTRL_PRIO_LSB +: NUM_PRIO];
            s_d.auto_xon = m[CTRL_AUTO_XON];
            s_d.pfc_en = m[CTRL_PFC_EN];
            s_d.lfc_en = m[CTRL_LFC_EN];
         end
         if (hit[IDX_SA_LO]) begin
            s_d.sa[SA_LO_W-1:0] = tfc_merge(s_q.sa[SA_LO_W-1:0], pwdata, pstrb);
         end
         if (hit[IDX_SA_HI]) begin
            m = tfc_merge({16'h0, s_q.sa[SA_W-1:SA_LO_W]}, pwdata, pstrb);
            s_d.sa[SA_W-1:SA_LO_W] = m[SA_HI_W-1:0];
         end
         if (hit[IDX_MTU]) begin
            m = tfc_merge(tfc_mtu_word(s_q), pwdata, pstrb);
            s_d.mtu_size = m[MTU_W-1:0];
            s_d.mtu_en = m[MTU_EN_BIT];
         end
      end

      s_d.max_len = s_q.mtu_en ? s_q.mtu_size : STD_MAX_LEN;

      // Frame arbiter: pause before resume, lowest priority index first
      case (s_q.arb)
         ARB_IDLE: begin
            if (s_q.pfc_en) begin
               for (int i = NUM_PRIO - 1; i >= 0; i--) begin
                  if (xon_p[i] && s_q.prio_en[i]) begin
                     pick_v = 1'b1;
                     pick_x = 1'b1;
                     pick_i = 2'(i);
                  end
               end
               for (int i = NUM_PRIO - 1; i >= 0; i--) begin
                  if (xoff_p[i] && s_q.prio_en[i]) begin
                     pick_v = 1'b1;
                     pick_x = 1'b0;
                     pick_i = 2'(i);
                  end
               end
            end
            if (pick_v) begin
               s_d.start = 1'b1;
               s_d.cur_prio = pick_i;
               s_d.cur_xon = pick_x;
               s_d.arb = ARB_SEND;
               s_d.frames = s_q.frames + 8'h01;
               if (pick_x) begin
                  gn[pick_i] = 1'b1;
               end else begin
                  gx[pick_i] = 1'b1;
               end
            end
         end
         ARB_SEND: begin
            if (!s_q.start && !oif.busy) begin
               s_d.arb = ARB_IDLE;
            end
         end
         default: begin
            s_d.arb = ARB_IDLE;
         end
      endcase

      if (sys_rst) begin
         s_d = '0;
         s_d.mtu_size = MTU_RST;
         s_d.max_len = STD_MAX_LEN;
         gx = '0;
         gn = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      s_q <= s_d;
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign fc_frame_start = s_q.start;
   assign fc_frame_prio = s_q.cur_prio;
   assign fc_frame_xon = s_q.cur_xon;
   assign fc_sa_octet = oif.octet;
   assign fc_sa_valid = oif.valid;
   assign fc_sa_last = oif.last;
   assign tx_max_len = s_q.max_len;
   assign tx_mtu_limit_en = s_q.mtu_en;
   assign pfc_on = s_q.pfc_en;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   prio_gate_a: assert property (fc_frame_start && !fc_frame_xon |-> $past(s_q.prio_en[s_d.cur_prio]))
      else $error("frame for disabled priority");
   pfc_gate_a: assert property (fc_frame_start |-> $past(s_q.pfc_en))
      else $error("frame without pfc");
   pfc_quiet_a: assert property (!s_q.pfc_en |=> !fc_frame_start)
      else $error("frame while pfc off");
   xon_src_a: assert property (fc_frame_start && fc_frame_xon |-> $past(|xon_p))
      else $error("resume without request");
   pause_first_a: assert property (s_q.arb == ARB_IDLE && s_q.pfc_en && |(xoff_p & s_q.prio_en) |=> !fc_frame_xon)
      else $error("resume before pause");
   frame_gap_a: assert property (fc_frame_start |=> !fc_frame_start [*7])
      else $error("frames too close");
   sa_len_a: assert property (fc_frame_start |=> fc_sa_valid [*6] ##1 !fc_sa_valid)
      else $error("address not six octets");
   sa_first_a: assert property (fc_frame_start |=> fc_sa_octet == $past(s_q.sa[7:0]))
      else $error("first octet not lsb");
   sa_mid_a: assert property (fc_frame_start |=> ##2 fc_sa_octet == $past(s_q.sa[16 +: 8]))
      else $error("third octet wrong");
   sa_last_a: assert property (fc_sa_last |-> fc_sa_octet == $past(s_q.sa[SA_W-1 -: 8]) && $past(fc_sa_valid, 5))
      else $error("last octet wrong");
   mtu_on_a: assert property ($past(s_q.mtu_en) |-> tx_max_len == $past(s_q.mtu_size))
      else $error("mtu size not used");
   mtu_off_a: assert property (!$past(s_q.mtu_en) |-> tx_max_len == STD_MAX_LEN)
      else $error("default length wrong");

   apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("apb answer timing");
   slverr_a: assert property (psel && !penable && hit == '0 |=> pslverr && prdata == 32'h0)
      else $error("unmapped not refused");
   wr_rdata_a: assert property (psel && !penable && pwrite |=> prdata == 32'h0)
      else $error("write returned data");
   sa_lo_rd_a: assert property (psel && !penable && !pwrite && hit[IDX_SA_LO]
      |=> prdata == $past(s_q.sa[SA_LO_W-1:0])) else $error("address low word read");
   sa_hi_rd_a: assert property (psel && !penable && !pwrite && hit[IDX_SA_HI]
      |=> prdata == {16'h0, $past(s_q.sa[SA_W-1:SA_LO_W])}) else $error("address high word read");
   ctrl_wr_a: assert property (psel && penable && pready && pwrite && hit[IDX_CTRL] && pstrb[0]
      |=> pfc_on == $past(pwdata[CTRL_PFC_EN])) else $error("pfc enable write lost");
   mtu_wr_a: assert property (psel && penable && pready && pwrite && hit[IDX_MTU] && pstrb[MTU_EN_BIT/8]
      |=> tx_mtu_limit_en == $past(pwdata[MTU_EN_BIT])) else $error("mtu enable write lost");

   xoff_cv: cover property (fc_frame_start && !fc_frame_xon);
   xon_cv: cover property (fc_frame_start && fc_frame_xon);
   write_cv: cover property (psel && penable && pready && pwrite && !pslverr);
   gap_cv: cover property (fc_frame_start ##9 fc_frame_start);
endmodule
`default_nettype wire

// ==== tfc_pkg.sv ====
`default_nettype none
// How it works
// - Per-priority enable gates each pause request
// - Auto XON sends zero quanta after release of a long request
// - Global PFC enable gates all priority frames
// - Pause source address fills generated frames
// - Source address never touches main datapath
// - Address least significant byte goes first
// - MTU enable selects configured max length
package tfc_pkg;
   localparam int NUM_PRIO = 3;
   localparam int SA_W = 48;
   localparam int MTU_W = 15;
   localparam int ADDR_W = 8;
   localparam int NUM_REG = 5;
   localparam logic [2:0] SA_OCT = 3'h6;
   localparam logic [2:0] OCT_LAST = 3'h5;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_SA_LO = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SA_HI = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_MTU = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h10;
   localparam int IDX_CTRL = 0;
   localparam int IDX_SA_LO = 1;
   localparam int IDX_SA_HI = 2;
   localparam int IDX_MTU = 3;
   localparam int IDX_STAT = 4;
   localparam int CTRL_PRIO_LSB = 0;
   localparam int CTRL_AUTO_XON = 3;
   localparam int CTRL_PFC_EN = 4;
   localparam int CTRL_LFC_EN = 5;
   localparam int SA_LO_W = 32;
   localparam int SA_HI_W = 16;
   localparam int MTU_EN_BIT = 16;
   localparam int STAT_XOFF_LSB = 0;
   localparam int STAT_XON_LSB = 4;
   localparam int STAT_BUSY = 8;
   localparam int STAT_CONFLICT = 9;
   localparam int STAT_FRAMES_LSB = 24;
   localparam logic [MTU_W-1:0] MTU_RST = 15'h05EE;
   localparam logic [MTU_W-1:0] STD_MAX_LEN = 15'h05EE;
   typedef enum logic {ARB_IDLE, ARB_SEND} tfc_arb_t;
endpackage
`default_nettype wire

// ==== tfc_oct_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface tfc_oct_if;
   logic start;
   logic [47:0] addr;
   logic [7:0] octet;
   logic valid;
   logic last;
   logic busy;
   modport mst (output start, output addr, input octet, input valid, input last, input busy);
   modport slv (input start, input addr, output octet, output valid, output last, output busy);
endinterface
`default_nettype wire

// ==== tfc_prio_track.sv ====
`timescale 1ns/1ps
`default_nettype none
module tfc_prio_track (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic req,
   input wire logic enable,
   input wire logic auto_xon,
   input wire logic grant_xoff,
   input wire logic grant_xon,
   output logic pend_xoff,
   output logic pend_xon
);
   import tfc_pkg::*;
   typedef struct packed {
      logic req_q;
      logic long_q;
      logic xoff_q;
      logic xon_q;
   } tfc_trk_st_t;
   tfc_trk_st_t s_q;
   tfc_trk_st_t s_d;
   logic act;

   always_comb begin
      act = req & enable;
      s_d = s_q;
      s_d.req_q = act;
      s_d.long_q = act & s_q.req_q;
      if (grant_xoff || !enable) begin
         s_d.xoff_q = 1'b0;
      end
      if (grant_xon || !enable) begin
         s_d.xon_q = 1'b0;
      end
      // Request edge asks for a pause frame
      if (act && !s_q.req_q) begin
         s_d.xoff_q = 1'b1;
      end
      // Release after a long request asks for zero quanta
      if (s_q.req_q && s_q.long_q && !req && enable && auto_xon) begin
         s_d.xon_q = 1'b1;
      end
      if (sys_rst) begin
         s_d = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      s_q <= s_d;
   end

   assign pend_xoff = s_q.xoff_q;
   assign pend_xon = s_q.xon_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   xoff_set_a: assert property (req && enable && !s_q.req_q |=> pend_xoff) else $error("edge lost");
   gate_off_a: assert property (!enable |=> !pend_xoff && !pend_xon) else $error("disabled pend");
   xon_set_a: assert property (s_q.long_q && !req && enable && auto_xon |=> pend_xon) else $error("no xon");
   short_req_a: assert property (req && enable && !s_q.req_q ##1 !req && !pend_xon |=> !pend_xon)
      else $error("xon after one cycle");
   xon_cv: cover property (s_q.long_q ##1 !req ##1 pend_xon);
endmodule
`default_nettype wire

// ==== tfc_sa_ser.sv ====
`timescale 1ns/1ps
`default_nettype none
module tfc_sa_ser (
   input wire logic clk_sys,
   input wire logic sys_rst,
   tfc_oct_if.slv oif
);
   import tfc_pkg::*;
   typedef struct packed {
      logic busy;
      logic [2:0] idx;
      logic [7:0] octet;
      logic valid;
      logic last;
   } tfc_ser_st_t;
   tfc_ser_st_t s_q;
   tfc_ser_st_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.valid = 1'b0;
      s_d.last = 1'b0;
      if (!s_q.busy) begin
         if (oif.start) begin
            s_d.busy = 1'b1;
            s_d.idx = 3'h1;
            s_d.octet = oif.addr[7:0];
            s_d.valid = 1'b1;
         end
      end else if (s_q.idx == SA_OCT) begin
         s_d.busy = 1'b0;
      end else begin
         s_d.octet = oif.addr[{s_q.idx, 3'h0} +: 8];
         s_d.valid = 1'b1;
         s_d.last = (s_q.idx == OCT_LAST);
         s_d.idx = s_q.idx + 3'h1;
      end
      if (sys_rst) begin
         s_d = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      s_q <= s_d;
   end

   assign oif.octet = s_q.octet;
   assign oif.valid = s_q.valid;
   assign oif.last = s_q.last;
   assign oif.busy = s_q.busy;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   octet_run_a: assert property (oif.valid && !oif.last |=> oif.valid) else $error("gap in address");
endmodule
`default_nettype wire

// ==== tfc_user_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tfc_user_model (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [2:0] req_cmd,
   input wire logic fc_frame_start,
   input wire logic [1:0] fc_frame_prio,
   input wire logic fc_frame_xon,
   input wire logic [7:0] fc_sa_octet,
   input wire logic fc_sa_valid,
   input wire logic fc_sa_last,
   output logic [2:0] req_q,
   output logic [7:0] done_cnt,
   output logic [1:0] seen_prio,
   output logic seen_xon,
   output logic [47:0] seen_sa
);
   // Same-clock user logic: request levels, frame collector
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         req_q <= 3'h0;
         done_cnt <= 8'h00;
         seen_prio <= 2'h0;
         seen_xon <= 1'b0;
         seen_sa <= 48'h0;
      end else begin
         req_q <= req_cmd;
         if (fc_frame_start) begin
            seen_prio <= fc_frame_prio;
            seen_xon <= fc_frame_xon;
         end
         // First octet lands in the low byte
         if (fc_sa_valid) begin
            seen_sa <= {fc_sa_octet, seen_sa[47:8]};
         end
         if (fc_sa_valid && fc_sa_last) begin
            done_cnt <= done_cnt + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tfc_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module tfc_top_test;
   import tfc_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [2:0] req_cmd = 3'h0;
   logic [2:0] req_q;
   logic fc_frame_start, fc_frame_xon, fc_sa_valid, fc_sa_last, tx_mtu_limit_en, pfc_on;
   logic [1:0] fc_frame_prio;
   logic [7:0] fc_sa_octet;
   logic [MTU_W-1:0] tx_max_len;
   logic [7:0] done_cnt;
   logic [1:0] seen_prio;
   logic seen_xon;
   logic [47:0] seen_sa;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;

   always #5 clk_sys = ~clk_sys;

   tfc_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prio0_pause_request(req_q[0]), .prio1_pause_request(req_q[1]), .prio2_pause_request(req_q[2]),
      .fc_frame_start(fc_frame_start), .fc_frame_prio(fc_frame_prio), .fc_frame_xon(fc_frame_xon),
      .fc_sa_octet(fc_sa_octet), .fc_sa_valid(fc_sa_valid), .fc_sa_last(fc_sa_last),
      .tx_max_len(tx_max_len), .tx_mtu_limit_en(tx_mtu_limit_en), .pfc_on(pfc_on));

   tfc_user_model u_user (.clk_sys(clk_sys), .sys_rst(sys_rst), .req_cmd(req_cmd),
      .fc_frame_start(fc_frame_start), .fc_frame_prio(fc_frame_prio), .fc_frame_xon(fc_frame_xon),
      .fc_sa_octet(fc_sa_octet), .fc_sa_valid(fc_sa_valid), .fc_sa_last(fc_sa_last), .req_q(req_q),
      .done_cnt(done_cnt), .seen_prio(seen_prio), .seen_xon(seen_xon), .seen_sa(seen_sa));

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready is seen high
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) begin
         @(posedge clk_sys);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(a, 1'b1, d, r, e);
      repeat (2) @(posedge clk_sys);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic e;
      apb(a, 1'b0, 32'h0, r, e);
      chk(r, exp);
      chk(e, exp_err);
   endtask

   // Raise a request set, hold it, drop it, let frames drain
   task automatic pulse(input logic [2:0] v, input int hold);
      @(posedge clk_sys);
      req_cmd <= v;
      repeat (hold + 1) @(posedge clk_sys);
      req_cmd <= 3'h0;
      repeat (60) @(posedge clk_sys);
   endtask

   task automatic frame_chk(input logic [7:0] n, input logic [1:0] p, input logic x);
      chk(done_cnt, n);
      chk(seen_prio, p);
      chk(seen_xon, x);
      chk(seen_sa, 48'hFFEEDDCCBBAA);
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         summarize();
      end
   end

   initial begin
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      chk(tx_max_len, MTU_RST);
      rd_chk(OFS_CTRL, 32'h0, 1'b0);
      rd_chk(OFS_MTU, {17'h0, MTU_RST}, 1'b0);
      rd_chk(8'h14, 32'h0, 1'b1);
      wr(OFS_SA_LO, 32'hDDCCBBAA);
      wr(OFS_SA_HI, 32'h0000FFEE);
      rd_chk(OFS_SA_LO, 32'hDDCCBBAA, 1'b0);
      // Legacy pause bit stays clear in every control write
      wr(OFS_CTRL, 32'h00000007);
      chk(pfc_on, 1'b0);
      pulse(3'h1, 4);
      chk(done_cnt, 8'h00);
      wr(OFS_CTRL, 32'h00000015);
      chk(pfc_on, 1'b1);
      pulse(3'h2, 4);
      chk(done_cnt, 8'h00);
      pulse(3'h1, 4);
      frame_chk(8'h01, 2'h0, 1'b0);
      pulse(3'h4, 4);
      frame_chk(8'h02, 2'h2, 1'b0);
      wr(OFS_CTRL, 32'h0000001D);
      pulse(3'h1, 4);
      frame_chk(8'h04, 2'h0, 1'b1);
      pulse(3'h1, 0);
      frame_chk(8'h05, 2'h0, 1'b0);
      pulse(3'h5, 4);
      frame_chk(8'h09, 2'h2, 1'b1);
      rd_chk(OFS_STAT, 32'h09000000, 1'b0);
      wr(OFS_CTRL, 32'h0000000F);
      chk(pfc_on, 1'b0);
      pulse(3'h1, 4);
      chk(done_cnt, 8'h09);
      wr(OFS_MTU, 32'h00012400);
      chk(tx_max_len, 15'h2400);
      chk(tx_mtu_limit_en, 1'b1);
      wr(OFS_MTU, 32'h00002400);
      chk(tx_max_len, STD_MAX_LEN);
      chk(tx_mtu_limit_en, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire
